// ==== core/asf_device.sv ====
// converter end of the serial frame link: frame shifter, result buffer, ready
// assumes: link pins pass two flip-flops; results arrive as a strobe from the core
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module asf_device
   import asf_pkg::*;
#(
   parameter int CONV_PERIOD = 64
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       ce,
   asf_link_if.device                      link,
   input  wire logic                       conv_valid,
   input  wire logic [ASF_RESULT_BITS-1:0] conv_data0,
   input  wire logic [ASF_RESULT_BITS-1:0] conv_data1,
   input  wire logic [1:0]                 cfg_wlen,
   input  wire logic                       cfg_crc_en,
   input  wire logic                       cfg_ready_pulse,
   input  wire logic                       cfg_ch_enable,
   output logic                            overflow,
   output logic [15:0]                     spare_zero_word
);
   localparam int NW = ASF_CHANNELS + 2;
   logic sclk_s, cs_s, sdi_s, sync_s, sclk_d;
   logic [ASF_RESULT_BITS-1:0] buf0 [2];
   logic [ASF_RESULT_BITS-1:0] buf1 [2];
   logic [1:0]  fill;
   logic [1:0]  wlen;
   logic [5:0]  bit_cnt;
   logic [2:0]  word_cnt;
   logic [31:0] shreg;
   logic [31:0] rxw;
   logic        in_frame;
   logic        full_read;
   logic [3:0]  pulse_cnt;
   logic [15:0] crc;
   logic        conv_ev;
   logic [15:0] mclk_cnt;
   logic [31:0] word0;
   logic [31:0] word_nx;

   asf_sync2 #(.INIT(1'b0)) u_sclk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.sclk), .q(sclk_s));
   asf_sync2 #(.INIT(1'b1)) u_cs (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.cs_n), .q(cs_s));
   asf_sync2 #(.INIT(1'b0)) u_sdi (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.sdi), .q(sdi_s));
   asf_sync2 #(.INIT(1'b1)) u_syn (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.sync_n), .q(sync_s));

   wire rise = sclk_s & ~sclk_d;
   wire fall = ~sclk_s & sclk_d;
   wire [5:0] wbits = 6'(asf_bits(wlen));

   function automatic logic [31:0] place(input logic [23:0] v, input logic [1:0] wl);
      unique case (wl)
         ASF_WLEN_16: place = {v[23:8], 16'h0000};
         ASF_WLEN_32: place = {{8{v[23]}}, v};
         default:     place = {v, 8'h00};
      endcase
   endfunction

   function automatic logic [31:0] frame_word(input logic [2:0] idx);
      logic [23:0] v;
      v = 24'h000000;
      unique case (idx)
         3'h0: v = {ASF_STATUS_TAG | {14'h0000, fill}, 8'h00};
         3'h1: v = buf0[0];
         3'h2: v = buf1[0];
         default: v = {crc, 8'h00};
      endcase
      if (idx == 3'h0 || idx == 3'h3)
         frame_word = (wlen == ASF_WLEN_32) ? {v, 8'h00} :
                      (wlen == ASF_WLEN_16) ? {v[23:8], 16'h0000} : {v, 8'h00};
      else
         frame_word = place(v, wlen);
   endfunction

   // first word of a frame and the word after the current one
   always_comb begin
      word0   = frame_word(3'h0);
      word_nx = frame_word(word_cnt + 3'h1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion timing, sync realigns the period counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mclk_cnt <= 16'h0000;
         conv_ev  <= 1'b0;
      end else if (ce) begin
         conv_ev <= 1'b0;
         if (!sync_s) begin
            mclk_cnt <= 16'h0000;
         end else if (conv_valid || mclk_cnt == 16'(CONV_PERIOD - 1)) begin
            mclk_cnt <= 16'h0000;
            conv_ev  <= 1'b1;
         end else begin
            mclk_cnt <= mclk_cnt + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-deep result buffer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf0[0]  <= 24'h000000;
         buf0[1]  <= 24'h000000;
         buf1[0]  <= 24'h000000;
         buf1[1]  <= 24'h000000;
         fill     <= 2'h0;
         overflow <= 1'b0;
      end else if (ce) begin
         if (conv_ev && full_read && fill != 2'h0) begin
            // frame end and new result together: pop the oldest, push the new one
            buf0[0]  <= (fill == 2'h2) ? buf0[1] : conv_data0;
            buf1[0]  <= (fill == 2'h2) ? buf1[1] : conv_data1;
            buf0[1]  <= conv_data0;
            buf1[1]  <= conv_data1;
            overflow <= 1'b0;
         end else if (conv_ev) begin
            if (fill == 2'h2) begin
               overflow <= 1'b1;
               buf0[0] <= buf0[1];
               buf1[0] <= buf1[1];
               buf0[1] <= conv_data0;
               buf1[1] <= conv_data1;
               fill    <= 2'h1;
            end else begin
               buf0[fill[0]] <= conv_data0;
               buf1[fill[0]] <= conv_data1;
               fill <= fill + 2'h1;
            end
         end else if (full_read && fill != 2'h0) begin
            buf0[0] <= buf0[1];
            buf1[0] <= buf1[1];
            fill    <= fill - 2'h1;
            overflow <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial frame shifter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_d    <= 1'b0;
         wlen      <= ASF_WLEN_RESET;
         bit_cnt   <= 6'h00;
         word_cnt  <= 3'h0;
         shreg     <= 32'h00000000;
         rxw       <= 32'h00000000;
         in_frame  <= 1'b0;
         full_read <= 1'b0;
         crc       <= 16'h0000;
         spare_zero_word <= ASF_SPARE_RESET;
         link.sdo_o  <= 1'b0;
         link.sdo_oe <= 1'b0;
      end else if (ce) begin
         sclk_d    <= sclk_s;
         full_read <= 1'b0;
         link.sdo_oe <= ~cs_s;
         if (cs_s) begin
            if (in_frame) begin
               // short frame counts as consumed only while channels are off
               full_read <= (word_cnt >= 3'(NW - (cfg_crc_en ? 0 : 1)))
                            || !cfg_ch_enable;
               wlen <= cfg_wlen;
            end
            in_frame <= 1'b0;
            bit_cnt  <= 6'h00;
            word_cnt <= 3'h0;
         end else if (!in_frame) begin
            in_frame   <= 1'b1;
            shreg      <= word0;
            link.sdo_o <= word0[31];
            crc        <= 16'h0000;
         end else begin
            if (rise) begin
               rxw <= {rxw[30:0], sdi_s};
               crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ shreg[31]) ? 16'h1021 : 16'h0000);
            end
            if (fall) begin
               if (bit_cnt == wbits - 6'h01) begin
                  bit_cnt  <= 6'h00;
                  word_cnt <= word_cnt + 3'h1;
                  shreg      <= word_nx;
                  link.sdo_o <= word_nx[31];
               end else begin
                  bit_cnt    <= bit_cnt + 6'h01;
                  shreg      <= {shreg[30:0], 1'b0};
                  link.sdo_o <= shreg[30];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ready output: level until read, or short pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.result_ready_n <= 1'b1;
         pulse_cnt <= 4'h0;
      end else if (ce) begin
         if (conv_ev && fill != 2'h2) begin
            link.result_ready_n <= 1'b0;
            pulse_cnt <= 4'(ASF_READY_PULSE);
         end else if (cfg_ready_pulse && pulse_cnt != 4'h0) begin
            pulse_cnt <= pulse_cnt - 4'h1;
            if (pulse_cnt == 4'h1)
               link.result_ready_n <= 1'b1;
         end else if (!cfg_ready_pulse && !cs_s) begin
            link.result_ready_n <= 1'b1;
         end
      end
   end
endmodule // asf_device

// ==== core/asf_host.sv ====
// host end: AHB-Lite slave registers driving frame reads from the converter
// assumes: converter end attached through the link interface
`timescale 1ns/100ps
module asf_host
   import asf_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   asf_link_if.host         link,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   typedef enum logic [1:0] {
      ASF_IDLE  = 2'b00,
      ASF_SHIFT = 2'b01,
      ASF_GAP   = 2'b10
   } asf_state_t;
   asf_state_t  state;
   logic [6:0]  ctrl;
   logic [31:0] word_rx [4];
   logic [31:0] frames;
   logic [31:0] cur;
   logic [5:0]  bitn;
   logic [2:0]  wordn;
   logic [3:0]  half;
   logic [2:0]  mdiv;
   logic [1:0]  flush_left;
   logic        rdy_s, rdy_d, sdo_s, wr_pend, busy;
   logic [7:0]  addr_q;

   asf_sync2 #(.INIT(1'b1)) u_rdy (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.result_ready_n), .q(rdy_s));
   asf_sync2 #(.INIT(1'b0)) u_sdo (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .d(link.sdo_o), .q(sdo_s));

   wire [5:0] wbits  = 6'(asf_bits(ctrl[ASF_CTRL_WLEN +: 2]));
   wire [2:0] nwords = ctrl[ASF_CTRL_SHORT] ? 3'h1 : 3'(ASF_CHANNELS + 1);
   wire [2:0] fwords = nwords + (ctrl[ASF_CTRL_CRC] ? 3'h1 : 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // bus slave, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         addr_q    <= 8'h00;
         ctrl      <= 7'h02;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         if (wr_pend && addr_q == ASF_REG_CTRL)
            ctrl <= hwdata[6:0];
         else if (busy)
            ctrl[ASF_CTRL_FLUSH] <= 1'b0;
         wr_pend <= hsel && htrans[1] && hwrite;
         addr_q  <= haddr;
         if (hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
               ASF_REG_CTRL:   hrdata <= {25'h0, ctrl};
               ASF_REG_STATUS: hrdata <= {29'h0, busy, ~rdy_s, flush_left != 2'h0};
               ASF_REG_DATA0:  hrdata <= word_rx[1];
               ASF_REG_DATA1:  hrdata <= word_rx[2];
               ASF_REG_FSTAT:  hrdata <= word_rx[0];
               ASF_REG_FRAMES: hrdata <= frames;
               default:        hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master clock divider and sync line, low while the control sync bit is set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mdiv <= 3'h0;
         link.master_clock_in <= 1'b0;
         link.sync_n <= 1'b1;
      end else if (ce) begin
         mdiv <= mdiv + 3'h1;
         if (mdiv == 3'(ASF_MCLK_DIV / 2 - 1))
            link.master_clock_in <= ~link.master_clock_in;
         link.sync_n <= ~ctrl[ASF_CTRL_SYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame reader
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ASF_IDLE;
         rdy_d <= 1'b1;
         busy  <= 1'b0;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.sdi  <= 1'b0;
         cur   <= 32'h0;
         bitn  <= 6'h0;
         wordn <= 3'h0;
         half  <= 4'h0;
         frames <= 32'h0;
         flush_left <= 2'h0;
         for (int i = 0; i < 4; i++)
            word_rx[i] <= 32'h0;
      end else if (ce) begin
         rdy_d <= rdy_s;
         unique case (state)
            ASF_IDLE: begin
               if (ctrl[ASF_CTRL_FLUSH])
                  flush_left <= 2'h2;
               if (ctrl[ASF_CTRL_RUN] && ((rdy_d && !rdy_s) || flush_left != 2'h0)) begin
                  state <= ASF_SHIFT;
                  busy  <= 1'b1;
                  link.cs_n <= 1'b0;
                  bitn <= 6'h0;
                  wordn <= 3'h0;
                  half <= 4'h0;
               end
            end
            ASF_SHIFT: begin
               half <= half + 4'h1;
               if (half == 4'(ASF_SCLK_HALF - 1)) begin
                  half <= 4'h0;
                  link.sclk <= ~link.sclk;
                  if (!link.sclk) begin
                     cur <= {cur[30:0], sdo_s};
                  end else begin
                     if (bitn == wbits - 6'h01) begin
                        bitn <= 6'h0;
                        // shorter words land in the low bits: align them to the top
                        word_rx[wordn[1:0]] <= cur << (6'h20 - wbits);
                        wordn <= wordn + 3'h1;
                        if (wordn + 3'h1 == fwords)
                           state <= ASF_GAP;
                     end else begin
                        bitn <= bitn + 6'h01;
                     end
                  end
               end
            end
            ASF_GAP: begin
               link.cs_n <= 1'b1;
               busy <= 1'b0;
               frames <= frames + 32'h1;
               if (flush_left != 2'h0)
                  flush_left <= flush_left - 2'h1;
               state <= ASF_IDLE;
            end
            default: state <= ASF_IDLE;
         endcase
      end
   end
endmodule // asf_host

// ==== core/asf_sync2.sv ====
// two flip-flop synchroniser for one pin level
// assumes: d comes from another clock domain
`timescale 1ns/100ps
module asf_sync2 #(
   parameter logic INIT = 1'b0
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   input  wire logic d,
   output logic      q
);
   logic meta;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= INIT;
         q    <= INIT;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // asf_sync2

// ==== pkg/asf_link_if.sv ====
// interface: serial frame link between converter and host
// assumes: output enable high while the converter drives its data line
`timescale 1ns/100ps
interface asf_link_if;
   logic master_clock_in;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   logic result_ready_n;
   logic sync_n;
   modport device (
      input  master_clock_in, sclk, cs_n, sdi, sync_n,
      output sdo_o, sdo_oe, result_ready_n
   );
   modport host (
      output master_clock_in, sclk, cs_n, sdi, sync_n,
      input  sdo_o, sdo_oe, result_ready_n
   );
endinterface

// ==== pkg/asf_pkg.sv ====
// package: constants of the converter serial frame link
// assumes: shared by both ends, the checker and the testbench
package asf_pkg;
   localparam int          ASF_CHANNELS      = 2;
   localparam int          ASF_RESULT_BITS   = 24;
   localparam logic [1:0]  ASF_WLEN_16       = 2'h0;
   localparam logic [1:0]  ASF_WLEN_24       = 2'h1;
   localparam logic [1:0]  ASF_WLEN_32       = 2'h2;
   localparam logic [1:0]  ASF_WLEN_RESET    = 2'h1;
   localparam logic [15:0] ASF_SPARE_RESET   = 16'h0000;
   localparam logic [15:0] ASF_STATUS_TAG    = 16'h0500;
   localparam int          ASF_MCLK_DIV      = 8;
   localparam int          ASF_SCLK_HALF     = 8;
   localparam int          ASF_READY_PULSE   = 4;
   // host register map, byte offsets
   localparam logic [7:0]  ASF_REG_CTRL      = 8'h00;
   localparam logic [7:0]  ASF_REG_STATUS    = 8'h04;
   localparam logic [7:0]  ASF_REG_DATA0     = 8'h08;
   localparam logic [7:0]  ASF_REG_DATA1     = 8'h0C;
   localparam logic [7:0]  ASF_REG_FSTAT     = 8'h10;
   localparam logic [7:0]  ASF_REG_FRAMES    = 8'h14;
   // control register bit positions
   localparam int          ASF_CTRL_RUN      = 0;
   localparam int          ASF_CTRL_WLEN     = 1;
   localparam int          ASF_CTRL_CRC      = 3;
   localparam int          ASF_CTRL_FLUSH    = 4;
   localparam int          ASF_CTRL_SYNC     = 5;
   localparam int          ASF_CTRL_SHORT    = 6;
   function automatic int asf_bits(input logic [1:0] wlen);
      return (wlen == ASF_WLEN_16) ? 16 : (wlen == ASF_WLEN_32) ? 32 : 24;
   endfunction
endpackage

// ==== test/asf_link_assertions.sv ====
// checker: wire relations on the link between the converter end and the host end
// assumes: instantiated beside the link interface, its signals passed as plain inputs
`timescale 1ns/100ps
module asf_link_assertions
   import asf_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic master_clock_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic result_ready_n,
   input wire logic sync_n
);
   logic       sclk_q;
   logic [7:0] bits;
   logic [7:0] head;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////////
   // counts captured bits in a frame and keeps the first byte seen on the wire
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_q <= 1'b0;
         bits   <= 8'h00;
         head   <= 8'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            bits <= 8'h00;
         end else if (sclk && !sclk_q) begin
            bits <= bits + 8'h01;
            if (bits < 8'h08) begin
               head <= {head[6:0], sdo_o};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_oe_off; cs_n [*5] |-> !sdo_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data line driven while deselected");
   property p_oe_sel; $rose(sdo_oe) |-> !cs_n; endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("driver enabled without select");
   property p_cs_hold; $fell(cs_n) |=> !cs_n [*8]; endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("select released early");
   property p_sclk_idle; cs_n [*8] |-> !sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs outside frame");
   property p_sdo_stable; ($rose(sclk) && !cs_n) |-> $stable(sdo_o) ##1 $stable(sdo_o); endproperty
   a_sdo_stable: assert property (p_sdo_stable) else $error("data moved at capture edge");
   property p_frame_len; $rose(cs_n) |-> bits[2:0] == 3'h0; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
   property p_status_head; (!cs_n && bits == 8'h08) |-> head == ASF_STATUS_TAG[15:8]; endproperty
   a_status_head: assert property (p_status_head) else $error("frame head not status");
   property p_mclk_runs; $rose(master_clock_in) |-> ##[1:16] $fell(master_clock_in); endproperty
   a_mclk_runs: assert property (p_mclk_runs) else $error("master clock stuck high");
endmodule // asf_link_assertions

// ==== test/asf_tb_top.sv ====
// testbench: host registers over the bus drive frame reads from the converter end
// assumes: both ends joined by the link interface, the checker beside it
`timescale 1ns/100ps
module asf_tb_top;
   import asf_pkg::*;
   localparam int CP = 2560;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_valid, overflow;
   logic        cfg_crc_en, cfg_ready_pulse, cfg_ch_enable;
   logic [1:0]  htrans, cfg_wlen;
   logic [2:0]  hsize;
   logic [7:0]  haddr;
   logic [15:0] spare_zero_word;
   logic [23:0] d0, d1;
   logic [31:0] hwdata, hrdata, r, f0;
   int          fail_count, tests_run, n, k;

   asf_link_if link ();
   asf_device #(.CONV_PERIOD(CP)) u_asf_device (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .link(link), .conv_valid(conv_valid), .conv_data0(d0), .conv_data1(d1),
      .cfg_wlen(cfg_wlen), .cfg_crc_en(cfg_crc_en), .cfg_ready_pulse(cfg_ready_pulse),
      .cfg_ch_enable(cfg_ch_enable), .overflow(overflow), .spare_zero_word(spare_zero_word));
   asf_host u_asf_host (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(link), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   asf_link_assertions u_asf_link_assertions (.hclk(hclk), .hresetn(hresetn),
      .master_clock_in(link.master_clock_in), .sclk(link.sclk), .cs_n(link.cs_n),
      .sdi(link.sdi), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
      .result_ready_n(link.result_ready_n), .sync_n(link.sync_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_frames(input int m);
      int i;
      i = 0;
      bus(1'b0, ASF_REG_FRAMES, 32'h0, f0);
      do begin
         repeat (64) @(posedge hclk);
         bus(1'b0, ASF_REG_FRAMES, 32'h0, r);
         i++;
      end while (r < f0 + 32'(m) && i < 400);
      if (r < f0 + 32'(m)) fail_count++;
   endtask

   // register image of one result word at each width, sign-extended at 32 bits
   function automatic logic [31:0] exp_word(input logic [1:0] wl, input logic [23:0] v);
      case (wl)
         ASF_WLEN_16: return {v[23:8], 16'h0000};
         ASF_WLEN_32: return {{8{v[23]}}, v};
         default:     return {v, 8'h00};
      endcase
   endfunction

   task automatic report_and_stop();
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial begin
      conv_valid = 1'b0;
      forever begin
         repeat (CP - 1) @(posedge hclk);
         conv_valid <= 1'b1;
         @(posedge hclk);
         conv_valid <= 1'b0;
      end
   end

   initial begin
      repeat (90000) @(posedge hclk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      {hresetn, hsel, hwrite, cfg_crc_en, cfg_ready_pulse} = '0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      cfg_wlen = ASF_WLEN_RESET;
      cfg_ch_enable = 1'b1;
      d0 = 24'h876543;
      d1 = 24'h2468AC;
      fail_count = 0;
      tests_run = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      bus(1'b0, ASF_REG_CTRL, 32'h0, r);
      chk(r, {29'h0, ASF_WLEN_RESET, 1'b0});
      chk({16'h0, spare_zero_word}, {16'h0, ASF_SPARE_RESET});
      chk({30'h0, link.result_ready_n, link.sdo_oe}, 32'h2);
      // unmapped place: write ignored, reads zero
      bus(1'b1, 8'h40, 32'hFFFF_FFFF, r);
      bus(1'b0, 8'h40, 32'h0, r);
      chk(r, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      for (k = 0; k < 3; k++) begin
         cfg_wlen <= k[1:0];
         cfg_crc_en <= (k == 2);
         d0 <= {~d0[23], d0[22:0]} ^ 24'h0F0F0F;
         d1 <= d1 + 24'h123457;
         bus(1'b1, ASF_REG_CTRL, {28'h0, k == 2, k[1:0], 1'b1}, r);
         wait_frames(4);
         bus(1'b0, ASF_REG_DATA0, 32'h0, r);
         chk(r, exp_word(k[1:0], d0));
         bus(1'b0, ASF_REG_DATA1, 32'h0, r);
         chk(r, exp_word(k[1:0], d1));
         bus(1'b0, ASF_REG_FSTAT, 32'h0, r);
         chk({24'h0, r[31:24]}, {24'h0, ASF_STATUS_TAG[15:8]});
      end
      // pulse format: low for a fixed count of cycles
      cfg_ready_pulse <= 1'b1;
      wait_frames(1);
      n = 0;
      while (link.result_ready_n !== 1'b0 && n < 2 * CP) begin
         @(posedge hclk);
         n++;
      end
      k = 0;
      while (link.result_ready_n === 1'b0 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      chk(k, ASF_READY_PULSE);
      // short frames with channels off, buffer flush must finish
      cfg_ch_enable <= 1'b0;
      bus(1'b1, ASF_REG_CTRL, 32'h0000_005D, r);
      n = 0;
      do begin
         repeat (64) @(posedge hclk);
         bus(1'b0, ASF_REG_STATUS, 32'h0, r);
         n++;
      end while (r[0] !== 1'b0 && n < 200);
      chk({31'h0, r[0]}, 32'h0);
      // stop reading: buffer overflows, ready falls every other period
      cfg_ch_enable <= 1'b1;
      bus(1'b1, ASF_REG_CTRL, 32'h0000_000C, r);
      repeat (3 * CP + 8) @(posedge hclk);
      chk({31'h0, overflow}, 32'h1);
      n = 0;
      k = (link.result_ready_n === 1'b1) ? 1 : 0;
      repeat (4 * CP) begin
         @(posedge hclk);
         if (k == 1 && link.result_ready_n === 1'b0) n++;
         k = (link.result_ready_n === 1'b1) ? 1 : 0;
      end
      chk(n, 2);
      report_and_stop();
   end
endmodule // asf_tb_top
